/* File: verilog/ltk_top.sv */
// Tone keying, tone detection and diagnostic flag logic
// Control bits arrive already decoded from the serial interface; pins are asynchronous
`timescale 1ns/100ps
`include "ltk_defs.svh"
module ltk_top
    import ltk_pkg::*;
#(
    parameter int EXT_START = `LTK_EXT_START_CYC,
    parameter int EXT_STOP = `LTK_EXT_STOP_CYC,
    parameter int ENV_START = `LTK_ENV_START_CYC,
    parameter int ENV_STOP = `LTK_ENV_STOP_CYC,
    parameter int DET_HOLD = `LTK_DET_HOLD_CYC
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic underVoltage,
    input wire logic toneOnBit,
    input wire logic externalToneSelect,
    input wire logic lowDissipationSelect,
    input wire logic [3:0] outputLevelSel,
    input wire logic statusRead,
    input wire logic toneKeyInput,
    input wire logic toneSenseInput,
    input wire logic overloadCause,
    input wire logic thermalCause,
    input wire logic supplyLowCause,
    input wire logic levelFaultCause,
    input wire logic toneQualityCause,
    input wire logic lightLoadCause,
    input wire logic sinkOvercurrentCause,
    output logic toneOut,
    output logic toneActive,
    output logic filterBypassDrive,
    output logic decodedToneOutput,
    output logic lowDropActive,
    output logic [3:0] outputLevel,
    output logic [3:0] statusA,
    output logic [3:0] statusB,
    output logic faultPinOut,
    output logic faultPinOe
);
    localparam int TW = `LTK_TIMER_W;

    // Two-stage synchronisers for all pins
    logic [9:0] pinMeta;
    logic [9:0] pinSync;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pinMeta <= 10'h000;
            pinSync <= 10'h000;
        end else begin
            pinMeta <= {underVoltage, toneKeyInput, toneSenseInput, overloadCause, thermalCause,
                        supplyLowCause, levelFaultCause, toneQualityCause, lightLoadCause, sinkOvercurrentCause};
            pinSync <= pinMeta;
        end
    end
    logic uvlo, keyIn, senseIn, cOver, cTherm, cSupply, cLevel, cQual, cLight, cSink;
    assign {uvlo, keyIn, senseIn, cOver, cTherm, cSupply, cLevel, cQual, cLight, cSink} = pinSync;

    // Control bits held cleared in undervoltage
    logic toneOn, extSel, lowDis;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            toneOn <= 1'b0;
            extSel <= 1'b0;
            lowDis <= 1'b0;
            outputLevel <= 4'h0;
        end else if (uvlo) begin
            toneOn <= 1'b0;
            extSel <= 1'b0;
            lowDis <= 1'b0;
            outputLevel <= 4'h0;
        end else begin
            toneOn <= toneOnBit;
            extSel <= externalToneSelect;
            lowDis <= lowDissipationSelect;
            outputLevel <= outputLevelSel;
        end
    end

    // Mode selection
    ltk_mode_t mode;
    always_comb begin
        if (!toneOn || uvlo) begin
            mode = LTK_MODE_OFF;
        end else if (extSel) begin
            mode = LTK_MODE_EXT;
        end else begin
            mode = LTK_MODE_ENV;
        end
    end

    // Internal tone source
    ltk_tone_if toneLink ();
    assign toneLink.run = (mode == LTK_MODE_ENV);
    ltk_tone_gen toneGen (
        .clock(clock),
        .rstn(rstn),
        .tone(toneLink)
    );

    // Key input edges and delayed copy for external mode
    logic keyPrev;
    logic [EXT_START-1:0] keyDelay;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            keyPrev <= 1'b0;
            keyDelay <= '0;
        end else begin
            keyPrev <= keyIn;
            keyDelay <= {keyDelay[EXT_START-2:0], keyIn};
        end
    end
    logic keyEdge;
    assign keyEdge = keyIn ^ keyPrev;

    // Keying state machine
    ltk_tone_state_t state, next_state;
    logic [TW-1:0] timer, next_timer;
    logic goOn, goOff;
    always_comb begin
        goOn = (mode == LTK_MODE_EXT) ? keyEdge : keyIn;
        goOff = (mode == LTK_MODE_EXT) ? !keyEdge : !keyIn;
        next_state = state;
        next_timer = (timer != '0) ? timer - TW'(1) : timer;
        unique case (state)
            LTK_IDLE: begin
                if (goOn) begin
                    next_state = LTK_START;
                    next_timer = (mode == LTK_MODE_EXT) ? TW'(EXT_START - 1) : TW'(ENV_START - 1);
                end
            end
            LTK_START: begin
                if (mode == LTK_MODE_ENV && !keyIn) begin
                    next_state = LTK_IDLE;
                end else if (timer == '0) begin
                    next_state = LTK_ON;
                end
            end
            LTK_ON: begin
                if (goOff) begin
                    next_state = LTK_STOP;
                    next_timer = (mode == LTK_MODE_EXT) ? TW'(EXT_STOP - 2) : TW'(ENV_STOP - 1);
                end
            end
            LTK_STOP: begin
                if (goOn) begin
                    next_state = LTK_ON;
                end else if (timer == '0) begin
                    next_state = LTK_IDLE;
                end
            end
        endcase
        if (mode == LTK_MODE_OFF) begin
            next_state = LTK_IDLE;
            next_timer = '0;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state <= LTK_IDLE;
            timer <= '0;
        end else begin
            state <= next_state;
            timer <= next_timer;
        end
    end

    // Tone output, bypass drive and low-drop indication
    logic sending;
    assign sending = (next_state == LTK_ON) || (next_state == LTK_STOP);
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            toneOut <= 1'b0;
            toneActive <= 1'b0;
            filterBypassDrive <= 1'b0;
            lowDropActive <= 1'b0;
        end else begin
            if (!sending) begin
                toneOut <= 1'b0;
            end else if (mode == LTK_MODE_EXT) begin
                toneOut <= keyDelay[EXT_START-2];
            end else begin
                toneOut <= toneLink.toneSq;
            end
            toneActive <= sending;
            filterBypassDrive <= sending;
            lowDropActive <= lowDis && !sending;
        end
    end

    // Tone detection on the sense input
    logic sensePrev;
    logic [TW-1:0] detTimer;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sensePrev <= 1'b0;
            detTimer <= '0;
            decodedToneOutput <= 1'b0;
        end else begin
            sensePrev <= senseIn;
            if (uvlo) begin
                detTimer <= '0;
            end else if (senseIn ^ sensePrev) begin
                detTimer <= TW'(DET_HOLD);
            end else if (detTimer != '0) begin
                detTimer <= detTimer - TW'(1);
            end
            decodedToneOutput <= (detTimer != '0);
        end
    end

    // Latched flags: set wins over the read clear
    logic latOver, latTherm, latSupply;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            latOver <= 1'b0;
            latTherm <= 1'b0;
            latSupply <= 1'b0;
        end else begin
            latOver <= cOver || (latOver && !statusRead);
            latTherm <= cTherm || (latTherm && !statusRead);
            latSupply <= cSupply || (latSupply && !statusRead);
        end
    end

    // Status registers and fault pin
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            statusA <= `LTK_STATUS_RESET;
            statusB <= `LTK_STATUS_RESET;
            faultPinOut <= 1'b0;
            faultPinOe <= 1'b0;
        end else begin
            statusA[`LTK_SA_LEVEL] <= cLevel;
            statusA[`LTK_SA_QUALITY] <= cQual;
            statusA[`LTK_SA_LIGHT] <= cLight;
            statusA[`LTK_SA_PRESENT] <= (detTimer != '0);
            statusB[`LTK_SB_OVERLOAD] <= latOver;
            statusB[`LTK_SB_THERMAL] <= latTherm;
            statusB[`LTK_SB_SUPPLY] <= latSupply;
            statusB[`LTK_SB_SINK] <= cSink;
            faultPinOut <= 1'b0;
            faultPinOe <= latOver || latTherm || latSupply;
        end
    end

endmodule : ltk_top

/* File: include/ltk_defs.svh */
// Constants for the tone keying and diagnostics block
// Assumes a 25 MHz core clock
`ifndef LTK_DEFS_SVH
`define LTK_DEFS_SVH

`define LTK_CLK_MHZ 25
// Least times round up, longest times round down
`define LTK_CYC_UP(ns) (((ns) * `LTK_CLK_MHZ + 999) / 1000)
`define LTK_CYC_DN(ns) (((ns) * `LTK_CLK_MHZ) / 1000)

`define LTK_TONE_HZ 22000
`define LTK_TONE_HALF ((`LTK_CLK_MHZ * 1000000) / (2 * `LTK_TONE_HZ))

`define LTK_EXT_START_NS 1000
`define LTK_EXT_STOP_NS 60000
`define LTK_ENV_START_NS 6000
`define LTK_ENV_STOP_NS 15000

`define LTK_EXT_START_CYC `LTK_CYC_UP(`LTK_EXT_START_NS)
`define LTK_EXT_STOP_CYC `LTK_CYC_DN(`LTK_EXT_STOP_NS)
`define LTK_ENV_START_CYC `LTK_CYC_UP(`LTK_ENV_START_NS)
`define LTK_ENV_STOP_CYC `LTK_CYC_UP(`LTK_ENV_STOP_NS)
// Sense input is called silent after two tone half periods without an edge
`define LTK_DET_HOLD_CYC (2 * `LTK_TONE_HALF)

`define LTK_TIMER_W 11

// Status field positions
`define LTK_SA_LEVEL 0
`define LTK_SA_QUALITY 1
`define LTK_SA_LIGHT 2
`define LTK_SA_PRESENT 3
`define LTK_SB_OVERLOAD 0
`define LTK_SB_THERMAL 1
`define LTK_SB_SUPPLY 2
`define LTK_SB_SINK 3
`define LTK_STATUS_RESET 4'h0

`endif

/* File: include/ltk_pkg.sv */
// Types for the tone keying and diagnostics block
// Shared by the top and the tone generator
package ltk_pkg;

    typedef enum logic [1:0] {
        LTK_IDLE = 2'b00,
        LTK_START = 2'b01,
        LTK_ON = 2'b10,
        LTK_STOP = 2'b11
    } ltk_tone_state_t;

    typedef enum logic [1:0] {
        LTK_MODE_OFF = 2'b00,
        LTK_MODE_EXT = 2'b01,
        LTK_MODE_ENV = 2'b10
    } ltk_mode_t;

endpackage : ltk_pkg

/* File: include/ltk_tone_if.sv */
// Link between the keying logic and the internal tone source
// Both ends share one clock
`timescale 1ns/100ps
interface ltk_tone_if;
    logic run;
    logic toneSq;
    modport gen (input run, output toneSq);
    modport user (output run, input toneSq);
endinterface : ltk_tone_if

/* File: verilog/ltk_tone_gen.sv */
// Internal 22 kHz square wave source
// Divides the core clock; restarts phase whenever run is low
`timescale 1ns/100ps
`include "ltk_defs.svh"
module ltk_tone_gen
    import ltk_pkg::*;
#(
    parameter int HALF = `LTK_TONE_HALF
) (
    input wire logic clock,
    input wire logic rstn,
    ltk_tone_if.gen tone
);
    logic [9:0] divCount;
    logic sq;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            divCount <= 10'h000;
            sq <= 1'b0;
        end else if (!tone.run) begin
            divCount <= 10'h000;
            sq <= 1'b0;
        end else if (divCount == 10'(HALF - 1)) begin
            divCount <= 10'h000;
            sq <= ~sq;
        end else begin
            divCount <= divCount + 10'h001;
        end
    end

    assign tone.toneSq = sq;

endmodule : ltk_tone_gen

/* File: sim/ltk_top_assertions.sv */
// Port checker for ltk_top
// Bound to every ltk_top; sees its ports only
`timescale 1ns/100ps
module ltk_top_assertions #(
    parameter int EXT_START = 25,
    parameter int ENV_START = 150
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic underVoltage,
    input wire logic toneOnBit,
    input wire logic externalToneSelect,
    input wire logic [3:0] outputLevelSel,
    input wire logic statusRead,
    input wire logic toneKeyInput,
    input wire logic levelFaultCause,
    input wire logic toneOut,
    input wire logic toneActive,
    input wire logic filterBypassDrive,
    input wire logic [3:0] outputLevel,
    input wire logic [3:0] statusA,
    input wire logic [3:0] statusB,
    input wire logic faultPinOut,
    input wire logic faultPinOe
);
    localparam int EXT_MAX = EXT_START + 6;
    localparam int ENV_LO = ENV_START - 5;
    localparam int ENV_HI = ENV_START + 4;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    chk_fault_pin_low: assert property (!faultPinOut && faultPinOe == |statusB[2:0])
        else $error("fault pin disagrees with latched flags");
    chk_bypass_follows: assert property (filterBypassDrive == toneActive && (filterBypassDrive || !toneOut))
        else $error("bypass drive differs from transmit state");
    chk_latch_no_drop: assert property (!statusRead && !$past(statusRead)
        |=> (statusB[2:0] & $past(statusB[2:0])) == $past(statusB[2:0]))
        else $error("latched flag dropped without a read");
    chk_undervolt_off: assert property (underVoltage[*5] |-> outputLevel == 4'h0 && !toneActive)
        else $error("outputs active in undervoltage");
    chk_level_follows: assert property ((!underVoltage && $stable(outputLevelSel))[*6]
        |-> outputLevel == outputLevelSel)
        else $error("level field not applied");
    chk_ext_start: assert property ($rose(toneKeyInput) && toneOnBit && externalToneSelect && !underVoltage
        && !toneActive |-> ##[1:EXT_MAX] toneActive)
        else $error("external tone late");
    chk_env_start: assert property ($rose(toneKeyInput) && toneOnBit && !externalToneSelect && !underVoltage
        && !toneActive |-> (!toneActive)[*4] ##[ENV_LO:ENV_HI] toneActive)
        else $error("envelope tone start out of window");
    chk_disabled_quiet: assert property (!toneOnBit && !$past(toneOnBit) && !toneActive |=> !toneActive)
        else $error("tone started while disabled");
    chk_live_flag: assert property ($stable(levelFaultCause)[*5] |-> statusA[0] == levelFaultCause)
        else $error("level flag does not track cause");
endmodule : ltk_top_assertions

bind ltk_top ltk_top_assertions #(.EXT_START(EXT_START), .ENV_START(ENV_START)) uChk (
    .clock(clock), .rstn(rstn), .underVoltage(underVoltage), .toneOnBit(toneOnBit),
    .externalToneSelect(externalToneSelect), .outputLevelSel(outputLevelSel), .statusRead(statusRead),
    .toneKeyInput(toneKeyInput), .levelFaultCause(levelFaultCause), .toneOut(toneOut), .toneActive(toneActive),
    .filterBypassDrive(filterBypassDrive), .outputLevel(outputLevel), .statusA(statusA),
    .statusB(statusB), .faultPinOut(faultPinOut), .faultPinOe(faultPinOe));

/* File: sim/ltk_key_source.sv */
// Tone keying source model on the key pin
// Runs on the core clock; host bits come from the bench
`timescale 1ns/100ps
module ltk_key_source #(
    parameter int HALF = 8
) (
    input wire logic clock,
    input wire logic burst,
    input wire logic square,
    output logic keyPin = 1'b0
);
    int count = 0;
    always @(posedge clock) begin
        if (!burst) begin
            keyPin <= 1'b0;
            count <= 0;
        end else if (!square) begin
            keyPin <= 1'b1;
        end else if (count == HALF - 1) begin
            keyPin <= ~keyPin;
            count <= 0;
        end else begin
            count <= count + 1;
        end
    end
endmodule : ltk_key_source

/* File: sim/tb_top.sv */
// Self-checking bench for ltk_top
// Key pin from ltk_key_source; host bits driven here
`timescale 1ns/100ps
module tb_top;
    logic clock = 1'b0, rstn = 1'b0, uv = 1'b0, toneOn = 1'b0, extSel = 1'b0, lowDiss = 1'b0;
    logic readPulse = 1'b0, sense = 1'b0, burst = 1'b0, square = 1'b0, keyPin, prev;
    logic [3:0] levelSel = 4'h0;
    logic [6:0] cause = 7'h00;
    logic toneOut, active, bypass, decoded, lowDrop, fOut, fOe;
    logic [3:0] levelOut, statA, statB;
    int numErrors = 0, nChecks = 0, cycles = 0, rises;
    initial forever #20 clock = ~clock;
    ltk_key_source partner (.clock(clock), .burst(burst), .square(square), .keyPin(keyPin));
    ltk_top #(.EXT_START(4), .EXT_STOP(20), .ENV_START(8), .ENV_STOP(10), .DET_HOLD(20)) dut (
        .clock(clock), .rstn(rstn), .underVoltage(uv), .toneOnBit(toneOn), .externalToneSelect(extSel),
        .lowDissipationSelect(lowDiss), .outputLevelSel(levelSel), .statusRead(readPulse),
        .toneKeyInput(keyPin), .toneSenseInput(sense), .overloadCause(cause[0]), .thermalCause(cause[1]),
        .supplyLowCause(cause[2]), .levelFaultCause(cause[3]), .toneQualityCause(cause[4]),
        .lightLoadCause(cause[5]), .sinkOvercurrentCause(cause[6]), .toneOut(toneOut), .toneActive(active),
        .filterBypassDrive(bypass), .decodedToneOutput(decoded), .lowDropActive(lowDrop),
        .outputLevel(levelOut), .statusA(statA), .statusB(statB), .faultPinOut(fOut), .faultPinOe(fOe));
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick
    task automatic check(input string name, input logic [3:0] exp, input logic [3:0] got);
        nChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic waitTone(input logic val, input int lim);
        for (int i = 0; i < lim && active !== val; i++) tick(1);
        check("toneActive", {3'h0, val}, {3'h0, active});
    endtask : waitTone
    task automatic countRises(input int n);
        rises = 0;
        for (int i = 0; i < n; i++) begin
            prev = toneOut;
            tick(1);
            if (toneOut === 1'b1 && prev === 1'b0) rises++;
        end
    endtask : countRises
    task automatic pulseRead();
        readPulse <= 1'b1;
        tick(1);
        readPulse <= 1'b0;
        tick(3);
    endtask : pulseRead
    task automatic reportAndStop();
        $display("checks %0d mismatches %0d", nChecks, numErrors);
        if (numErrors == 0 && nChecks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : reportAndStop
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            numErrors++;
            reportAndStop();
        end
    end
    initial begin
        tick(10);
        rstn <= 1'b1;
        tick(3);
        check("status", 4'h0, statA | statB);
        for (int v = 0; v < 16; v += 5) begin
            levelSel <= 4'(v);
            lowDiss <= v[0];
            tick(5);
            check("outputLevel", 4'(v), levelOut);
            check("lowDrop", {3'h0, v[0]}, {3'h0, lowDrop});
        end
        $display("test level done");
        lowDiss <= 1'b0;
        toneOn <= 1'b1;
        tick(2);
        burst <= 1'b1;
        tick(4);
        check("early", 4'h0, {3'h0, active});
        waitTone(1'b1, 20);
        check("bypass", 4'h1, {3'h0, bypass});
        countRises(1300);
        check("envRises", 4'h1, rises[3:0]);
        burst <= 1'b0;
        tick(5);
        check("stopHold", 4'h1, {3'h0, active});
        waitTone(1'b0, 30);
        extSel <= 1'b1;
        tick(2);
        square <= 1'b1;
        burst <= 1'b1;
        waitTone(1'b1, 25);
        tick(20);
        countRises(96);
        check("extRises", 4'h6, rises[3:0]);
        burst <= 1'b0;
        tick(12);
        check("extHold", 4'h1, {3'h0, active});
        waitTone(1'b0, 40);
        toneOn <= 1'b0;
        extSel <= 1'b0;
        square <= 1'b0;
        tick(2);
        burst <= 1'b1;
        tick(30);
        check("refused", 4'h0, {3'h0, active});
        burst <= 1'b0;
        $display("test tone done");
        for (int b = 0; b < 3; b++) begin
            cause[b] <= 1'b1;
            tick(6);
            check("latched", 4'h1 << b, statB & 4'h7);
            check("faultOe", 4'h1, {3'h0, fOe});
            pulseRead();
            cause[b] <= 1'b0;
            tick(6);
            check("held", 4'h1 << b, statB & 4'h7);
            pulseRead();
            check("cleared", 4'h0, {fOe, statB[2:0]});
        end
        for (int b = 3; b < 7; b++) begin
            cause[b] <= 1'b1;
            tick(5);
            check("live", 4'h1 << (b - 3), {statB[3], statA[2:0]});
            cause[b] <= 1'b0;
            tick(5);
            check("liveOff", 4'h0, {statB[3], statA[2:0]});
        end
        repeat (8) begin
            sense <= ~sense;
            tick(8);
        end
        check("detect", 4'h3, {2'h0, decoded, statA[3]});
        tick(40);
        check("silent", 4'h0, {2'h0, decoded, statA[3]});
        $display("test flags done");
        levelSel <= 4'hA;
        toneOn <= 1'b1;
        burst <= 1'b1;
        waitTone(1'b1, 20);
        uv <= 1'b1;
        tick(6);
        check("uvLevel", 4'h0, levelOut);
        check("uvTone", 4'h0, {3'h0, active});
        uv <= 1'b0;
        burst <= 1'b0;
        toneOn <= 1'b0;
        tick(8);
        check("uvBack", 4'hA, levelOut);
        $display("test undervoltage done");
        reportAndStop();
    end
endmodule : tb_top
